// File: logic/stop_recovery_pkg.sv
/*
 * constants, register map and state codes for the stop-state recovery block.
 * assumes a single 10 MHz system clock and a byte-wide register port.
 */
`default_nettype none
package stop_recovery_pkg;
    localparam int PIN_COUNT = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int PMEM_ADDR_W = 24;
    localparam int PC_W = 32;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_RSTSTAT = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_WAKE_EN = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h5;

    // field positions
    localparam int RST_STOP_BIT = 0;
    localparam int RST_WDT_BIT = 1;
    localparam int CTRL_WDT_EXC_BIT = 0;
    localparam int CTRL_STOP_REQ_BIT = 1;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_EXC_BIT = 1;
    localparam int STATE_OSC_BIT = 7;

    // reset values
    localparam logic [1:0] RSTSTAT_RESET = 2'h0;
    localparam logic [PIN_COUNT-1:0] WAKE_EN_RESET = 8'h00;
    localparam logic EXC_MODE_RESET = 1'b0;
    localparam logic [1:0] IRQ_STAT_RESET = 2'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic OSC_RUN_RESET = 1'b1;

    // reset vector location and fetch timing
    localparam logic [PMEM_ADDR_W-1:0] VECTOR_BASE = 24'h000004;
    localparam logic [2:0] VECTOR_BYTES = 3'h4;
    localparam logic [2:0] FETCH_FIRST_DATA = 3'h2;
    localparam logic [2:0] FETCH_LAST = 3'h5;

    typedef enum logic [4:0]
    {
        ST_RUN = 5'b00001,
        ST_STOP = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_LOAD = 5'b01000,
        ST_EXC = 5'b10000
    } rec_state_t;
endpackage : stop_recovery_pkg
`default_nettype wire

// File: logic/pin_sync.sv
/*
 * two-stage synchroniser for a group of asynchronous pins.
 * assumes the pins come from outside the clock domain; only q_out is read.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] d_in,
    output var logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    // first stage feeds only the second
    always_comb
    begin
        meta_next = d_in;
        q_next = meta_reg;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            meta_reg <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_out <= q_next;
        end
    end
endmodule : pin_sync
`default_nettype wire

// File: logic/stop_recovery_control.sv
/*
 * stop-state recovery control: watchdog and pin wake, cause flags,
 * reset vector fetch and program counter load, register port, interrupt.
 * assumes watchdog timeout and program memory are on clk_sys_in and that
 * program memory returns read data one cycle after its read strobe.
 */
// Behaviour
// - recovery changes only reset status and oscillator control; other state kept (code also sets wake interrupt flag at load, exception flag in exception mode)
// - on recovery fetch vector from bytes 0004h-0007h and load program counter
// - every recovery from stop sets the stop-cause flag to one
// - watchdog timeout while stopped starts recovery, sets watchdog and stop flags
// - watchdog in reset mode: timeout during stop gives recovery only
// - watchdog in exception mode: recovery completes, then watchdog exception raised
// - any level change on a wake-enabled pin starts recovery, sets stop flag
// - short pin pulse may wake without pin interrupt; do not rely on it
`timescale 1ns/1ps
`default_nettype none
module stop_recovery_control (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [stop_recovery_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [stop_recovery_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output var logic [stop_recovery_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic wdt_timeout_in,
    input wire logic [stop_recovery_pkg::PIN_COUNT-1:0] wake_pins_in,
    output var logic [stop_recovery_pkg::PMEM_ADDR_W-1:0] pmem_addr_out,
    output var logic pmem_rd_out,
    input wire logic [stop_recovery_pkg::DATA_W-1:0] pmem_data_in,
    output var logic pc_load_out,
    output var logic [stop_recovery_pkg::PC_W-1:0] pc_value_out,
    output var logic wdt_exc_out,
    output var logic cpu_stopped_out,
    output var logic osc_run_out,
    output var logic irq_out
);
    import stop_recovery_pkg::*;

    rec_state_t state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [PC_W-1:0] vec_reg, vec_next;
    logic wdt_cause_reg, wdt_cause_next;
    logic [PIN_COUNT-1:0] snap_reg, snap_next;
    logic [1:0] rststat_reg, rststat_next;
    logic [PIN_COUNT-1:0] wake_en_reg, wake_en_next;
    logic exc_mode_reg, exc_mode_next;
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic [DATA_W-1:0] rdata_next;
    logic [PMEM_ADDR_W-1:0] pmem_addr_next;
    logic pmem_rd_next, pc_load_next, wdt_exc_next, stopped_next, osc_run_next, irq_next;
    logic [PC_W-1:0] pc_value_next;
    logic [PIN_COUNT-1:0] pins_sync;
    logic pin_wake, stop_req, start_evt, done_evt, exc_evt;

    // pins cross into the clock domain before any comparison
    pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .d_in(wake_pins_in),
        .q_out(pins_sync)
    );

    // any enabled pin differing from its level at stop entry, either direction;
    // level path only, so a brief pulse can wake with no pin interrupt at all
    assign pin_wake = |((pins_sync ^ snap_reg) & wake_en_reg);
    // stop request: write of the stop bit in the control register
    assign stop_req = reg_wr_in && (reg_addr_in == ADDR_CTRL) && reg_wdata_in[CTRL_STOP_REQ_BIT];

    // recovery sequencer next state
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        vec_next = vec_reg;
        wdt_cause_next = wdt_cause_reg;
        snap_next = snap_reg;
        pmem_rd_next = 1'b0;
        pmem_addr_next = pmem_addr_out;
        pc_load_next = 1'b0;
        pc_value_next = pc_value_out;
        wdt_exc_next = 1'b0;
        osc_run_next = osc_run_out;
        start_evt = 1'b0;
        done_evt = 1'b0;
        exc_evt = 1'b0;
        unique case (state_reg)
            ST_RUN:
            begin
                if (stop_req)
                begin
                    state_next = ST_STOP;
                    snap_next = pins_sync;
                    osc_run_next = 1'b0;
                    wdt_cause_next = 1'b0;
                end
            end
            ST_STOP:
            begin
                if (wdt_timeout_in || pin_wake)
                begin
                    state_next = ST_FETCH;
                    cnt_next = 3'h0;
                    osc_run_next = 1'b1; // oscillator control, the wake interrupt flag at load and, in exception mode, the exception interrupt flag are the other registers touched
                    wdt_cause_next = wdt_timeout_in;
                    start_evt = 1'b1;
                end
            end
            ST_FETCH:
            begin
                // read strobes on counts 0..3, data lands two counts later
                if (cnt_reg < VECTOR_BYTES)
                begin
                    pmem_rd_next = 1'b1;
                    pmem_addr_next = VECTOR_BASE + {21'h000000, cnt_reg};
                end
                if (cnt_reg >= FETCH_FIRST_DATA)
                begin
                    vec_next = {vec_reg[PC_W-DATA_W-1:0], pmem_data_in}; // first byte most significant
                end
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == FETCH_LAST)
                begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                pc_load_next = 1'b1;
                pc_value_next = vec_reg;
                done_evt = 1'b1;
                // exception only after the normal sequence, only in exception mode
                if (wdt_cause_reg && exc_mode_reg)
                begin
                    state_next = ST_EXC;
                end
                else
                begin
                    state_next = ST_RUN;
                end
            end
            ST_EXC:
            begin
                wdt_exc_next = 1'b1;
                exc_evt = 1'b1;
                state_next = ST_RUN;
            end
            default:
            begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            state_reg <= ST_RUN;
            cnt_reg <= 3'h0;
            vec_reg <= '0;
            wdt_cause_reg <= 1'b0;
            snap_reg <= '0;
            pmem_rd_out <= 1'b0;
            pmem_addr_out <= '0;
            pc_load_out <= 1'b0;
            pc_value_out <= '0;
            wdt_exc_out <= 1'b0;
            osc_run_out <= OSC_RUN_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            vec_reg <= vec_next;
            wdt_cause_reg <= wdt_cause_next;
            snap_reg <= snap_next;
            pmem_rd_out <= pmem_rd_next;
            pmem_addr_out <= pmem_addr_next;
            pc_load_out <= pc_load_next;
            pc_value_out <= pc_value_next;
            wdt_exc_out <= wdt_exc_next;
            osc_run_out <= osc_run_next;
        end
    end

    // register file: write-one-to-clear flags with set winning, read data
    always_comb
    begin
        rststat_next = rststat_reg;
        wake_en_next = wake_en_reg;
        exc_mode_next = exc_mode_reg;
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        rdata_next = '0;
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                ADDR_RSTSTAT: rststat_next = rststat_reg & ~reg_wdata_in[1:0];
                ADDR_WAKE_EN: wake_en_next = reg_wdata_in;
                ADDR_CTRL: exc_mode_next = reg_wdata_in[CTRL_WDT_EXC_BIT];
                ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~reg_wdata_in[1:0];
                ADDR_IRQ_MASK: irq_mask_next = reg_wdata_in[1:0];
                default: rststat_next = rststat_reg;
            endcase
        end
        if (start_evt)
        begin
            rststat_next[RST_STOP_BIT] = 1'b1;
            if (wdt_timeout_in)
            begin
                rststat_next[RST_WDT_BIT] = 1'b1;
            end
        end
        if (done_evt)
        begin
            irq_stat_next[IRQ_WAKE_BIT] = 1'b1;
        end
        if (exc_evt)
        begin
            irq_stat_next[IRQ_EXC_BIT] = 1'b1;
        end
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                ADDR_RSTSTAT: rdata_next = {6'h00, rststat_reg};
                ADDR_WAKE_EN: rdata_next = wake_en_reg;
                ADDR_CTRL: rdata_next = {7'h00, exc_mode_reg};
                ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
                ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
                ADDR_STATE: rdata_next = {osc_run_out, 2'h0, state_reg};
                default: rdata_next = '0;
            endcase
        end
        stopped_next = (state_next != ST_RUN);
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            rststat_reg <= RSTSTAT_RESET;
            wake_en_reg <= WAKE_EN_RESET;
            exc_mode_reg <= EXC_MODE_RESET;
            irq_stat_reg <= IRQ_STAT_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            reg_rdata_out <= '0;
            cpu_stopped_out <= 1'b0;
            irq_out <= 1'b0;
        end
        else
        begin
            rststat_reg <= rststat_next;
            wake_en_reg <= wake_en_next;
            exc_mode_reg <= exc_mode_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            reg_rdata_out <= rdata_next;
            cpu_stopped_out <= stopped_next;
            irq_out <= irq_next;
        end
    end

    // checks on the recovery sequence
    property p_regs_kept;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg inside {ST_FETCH, ST_LOAD, ST_EXC}) && !reg_wr_in
            |=> $stable(wake_en_reg) && $stable(irq_mask_reg) && $stable(exc_mode_reg);
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("recovery altered kept registers");

    property p_osc_off;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg == ST_STOP) |-> !osc_run_out;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator running while stopped");

    property p_vector_fetch;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg == ST_FETCH && cnt_reg == 3'h0)
            |=> pmem_rd_out && pmem_addr_out == VECTOR_BASE ##3 pmem_rd_out && pmem_addr_out == 24'h000007 ##3 pc_load_out;
    endproperty
    a_vector_fetch: assert property (p_vector_fetch) else $error("vector fetch sequence wrong");

    property p_pin_stop_flag;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg == ST_STOP) && pin_wake |=> rststat_reg[RST_STOP_BIT] && state_reg == ST_FETCH;
    endproperty
    a_pin_stop_flag: assert property (p_pin_stop_flag) else $error("pin wake did not set stop flag");

    property p_wdt_flags;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg == ST_STOP) && wdt_timeout_in |=> rststat_reg == 2'h3 && state_reg == ST_FETCH;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog wake flags not set");

    property p_reset_mode;
        @(posedge clk_sys_in) disable iff (reset_in)
        pc_load_out && !exc_mode_reg |=> !wdt_exc_out [*2];
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("exception raised in reset mode");

    property p_exc_after_load;
        @(posedge clk_sys_in) disable iff (reset_in)
        pc_load_out && wdt_cause_reg && exc_mode_reg |=> wdt_exc_out ##1 !wdt_exc_out;
    endproperty
    a_exc_after_load: assert property (p_exc_after_load) else $error("exception not after load");

    property p_exc_cause;
        @(posedge clk_sys_in) disable iff (reset_in)
        wdt_exc_out |-> $past(pc_load_out) && $past(wdt_cause_reg, 2) && $past(exc_mode_reg, 2);
    endproperty
    a_exc_cause: assert property (p_exc_cause) else $error("exception without watchdog wake");

    property p_pin_wake;
        @(posedge clk_sys_in) disable iff (reset_in)
        (state_reg == ST_STOP) && !wdt_timeout_in && pin_wake |=> !wdt_cause_reg ##7 pc_load_out;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin change did not recover");
endmodule : stop_recovery_control
`default_nettype wire

// File: tb/wake_partner.sv
/*
 * far side of the recovery block: watchdog time-out, wake pins and program memory.
 * assumes the bench asks for events on clk_sys_in; memory answers one cycle after its strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module wake_partner #(
    parameter logic [31:0] VECTOR = 32'h0012_3456
) (
    input wire logic clk_sys_in,
    input wire logic wdt_fire_in,
    input wire logic [7:0] pin_level_in,
    input wire logic pmem_rd_in,
    input wire logic [23:0] pmem_addr_in,
    output var logic wdt_timeout_out,
    output var logic [7:0] pins_out,
    output var logic [7:0] pmem_data_out
);
    logic [7:0] byte_reg;
    // time-out pulse and pin levels follow the bench one cycle later
    always_ff @(posedge clk_sys_in)
    begin
        wdt_timeout_out <= wdt_fire_in;
        pins_out <= pin_level_in;
    end
    // first byte is the top one; between reads the bus flips to the inverse of its value every cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (pmem_rd_in)
        begin
            byte_reg <= VECTOR[8*(3-pmem_addr_in[1:0]) +: 8];
        end
        else
        begin
            byte_reg <= ~byte_reg;
        end
    end
    assign pmem_data_out = byte_reg;
endmodule : wake_partner
`default_nettype wire

// File: tb/stop_mode_recovery_control_bench.sv
/*
 * self-checking bench for stop-state recovery: register port, pin and watchdog wake.
 * assumes the partner model supplies watchdog, pins and program memory.
 */
`timescale 1ns/1ps
`default_nettype none
module stop_mode_recovery_control_bench;
    import stop_recovery_pkg::*;
    localparam logic [31:0] VEC = 32'h0012_3456;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wdt_fire = 1'b0;
    logic [7:0] pin_level = 8'h00;
    logic [DATA_W-1:0] rdata;
    logic [7:0] pins;
    logic [7:0] pmem_data;
    logic [23:0] pmem_addr;
    logic [31:0] pc_value;
    logic wdt_timeout, pmem_rd, pc_load, wdt_exc, stopped, osc_run, irq;
    logic load_d = 1'b0;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_exc = 0;
    int n_exc_late = 0;
    logic [23:0] adr_q[$];

    initial forever #50 clk_sys_in = ~clk_sys_in;

    stop_recovery_control dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .wdt_timeout_in(wdt_timeout), .wake_pins_in(pins), .pmem_addr_out(pmem_addr), .pmem_rd_out(pmem_rd),
        .pmem_data_in(pmem_data), .pc_load_out(pc_load), .pc_value_out(pc_value), .wdt_exc_out(wdt_exc),
        .cpu_stopped_out(stopped), .osc_run_out(osc_run), .irq_out(irq));
    wake_partner #(.VECTOR(VEC)) far (.clk_sys_in(clk_sys_in), .wdt_fire_in(wdt_fire), .pin_level_in(pin_level),
        .pmem_rd_in(pmem_rd), .pmem_addr_in(pmem_addr), .wdt_timeout_out(wdt_timeout), .pins_out(pins),
        .pmem_data_out(pmem_data));

    task close_out;
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // watch fetch addresses, exception pulses and the cycle ceiling
    always @(posedge clk_sys_in)
    begin
        load_d <= pc_load;
        cycles <= cycles + 1;
        if (pmem_rd === 1'b1)
            adr_q.push_back(pmem_addr);
        if (wdt_exc === 1'b1)
        begin
            n_exc <= n_exc + 1;
            if (load_d === 1'b1)
                n_exc_late <= n_exc_late + 1;
        end
        if (cycles == 5000)
        begin
            num_errors++;
            close_out;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask : wr

    task rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    // request stop and confirm the core is halted with the oscillator off
    task go_stop(input logic [DATA_W-1:0] v);
        wr(ADDR_CTRL, v);
        @(posedge clk_sys_in);
        #1;
        chk(stopped, 1'b1);
        chk(osc_run, 1'b0);
    endtask : go_stop

    task fire;
        @(posedge clk_sys_in);
        wdt_fire <= 1'b1;
        @(posedge clk_sys_in);
        wdt_fire <= 1'b0;
    endtask : fire

    // bounded wait for the vector load, then check fetch order and restart
    task wait_load;
        int i;
        i = 0;
        while (pc_load !== 1'b1 && i < 20)
        begin
            @(posedge clk_sys_in);
            #1;
            i++;
        end
        chk(pc_load, 1'b1);
        chk(pc_value, VEC);
        chk(adr_q.size(), 4);
        for (i = 0; i < adr_q.size(); i++)
            chk(adr_q[i], VECTOR_BASE + i);
        adr_q.delete();
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk(pc_load, 1'b0);
        chk(stopped, 1'b0);
        chk(osc_run, 1'b1);
    endtask : wait_load

    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        // reset values and an unmapped index
        rd_chk(ADDR_RSTSTAT, 8'h00);
        rd_chk(ADDR_WAKE_EN, 8'h00);
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_IRQ_STAT, 8'h00);
        rd_chk(ADDR_IRQ_MASK, 8'h00);
        rd_chk(ADDR_STATE, 8'h81);
        rd_chk(4'hf, 8'h00);
        // a time-out while running is not a wake
        fire;
        repeat (3) @(posedge clk_sys_in);
        rd_chk(ADDR_RSTSTAT, 8'h00);
        wr(ADDR_WAKE_EN, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h03);
        // disabled pin ignored, then rising edge on the enabled pin wakes
        go_stop(8'h02);
        rd_chk(ADDR_STATE, 8'h02);
        @(posedge clk_sys_in);
        pin_level <= 8'h02;
        repeat (8) @(posedge clk_sys_in);
        #1;
        chk(stopped, 1'b1);
        @(posedge clk_sys_in);
        pin_level <= 8'h03;
        wait_load;
        rd_chk(ADDR_RSTSTAT, 8'h01);
        rd_chk(ADDR_IRQ_STAT, 8'h01);
        chk(irq, 1'b1);
        chk(n_exc, 0);
        wr(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_RSTSTAT, 8'h01);
        rd_chk(ADDR_RSTSTAT, 8'h00);
        chk(irq, 1'b0);
        // other registers kept across recovery
        rd_chk(ADDR_WAKE_EN, 8'h01);
        rd_chk(ADDR_IRQ_MASK, 8'h03);
        rd_chk(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_STATE, 8'h81);
        // falling edge wakes as well
        go_stop(8'h02);
        @(posedge clk_sys_in);
        pin_level <= 8'h02;
        wait_load;
        rd_chk(ADDR_RSTSTAT, 8'h01);
        wr(ADDR_RSTSTAT, 8'h01);
        // one-cycle pulse still wakes
        go_stop(8'h02);
        @(posedge clk_sys_in);
        pin_level <= 8'h03;
        @(posedge clk_sys_in);
        pin_level <= 8'h02;
        wait_load;
        rd_chk(ADDR_RSTSTAT, 8'h01);
        wr(ADDR_RSTSTAT, 8'h01);
        wr(ADDR_IRQ_STAT, 8'h03);
        // watchdog in reset mode: recovery only
        go_stop(8'h02);
        fire;
        wait_load;
        repeat (3) @(posedge clk_sys_in);
        chk(n_exc, 0);
        rd_chk(ADDR_RSTSTAT, 8'h03);
        rd_chk(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_RSTSTAT, 8'h03);
        wr(ADDR_IRQ_STAT, 8'h03);
        // watchdog in exception mode: exception right after the load
        wr(ADDR_CTRL, 8'h01);
        go_stop(8'h03);
        fire;
        wait_load;
        repeat (3) @(posedge clk_sys_in);
        chk(n_exc, 1);
        chk(n_exc_late, 1);
        rd_chk(ADDR_IRQ_STAT, 8'h03);
        rd_chk(ADDR_RSTSTAT, 8'h03);
        rd_chk(ADDR_CTRL, 8'h01);
        close_out;
    end
endmodule : stop_mode_recovery_control_bench
`default_nettype wire
